/* logic/gdc_host.sv */
// Gate drive controller: pulse-width source and sequencer for a buck power stage
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module gdc_host #(
  parameter int DW = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  // Power stage pins
  output logic             pwm_o,
  output logic             pwm_oe,
  output logic             skip_mode_n_o,
  output logic             skip_mode_n_oe,
  output logic             driver_enable_n,
  input  wire logic        thermal_warn_n,
  input  wire logic        undervoltage_lockout,
  input  wire logic        over_current
);
  localparam int EV_W_C = gdc_pkg::EV_W;
  logic [31:0]          ctrl;
  logic [DW-1:0]        period;
  logic [DW-1:0]        duty_tgt;
  logic [DW-1:0]        step;
  logic [DW-1:0]        prescale;
  logic [EV_W_C-1:0]    irq_status;
  logic [EV_W_C-1:0]    irq_mask;

  logic [7:0]           aw_addr;
  logic                 aw_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 w_held;
  logic                 wr_go;
  logic                 wr_hit;

  gdc_pkg::gdc_state_t  state;
  logic [DW-1:0]        cnt;
  logic [DW-1:0]        duty_cur;
  logic                 tick;
  logic                 period_end;
  logic [7:0]           gap_cnt;
  logic                 warn_q;
  logic [EV_W_C-1:0]    ev;

  // Byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  gdc_tick_div #(.W(DW)) u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .divide  (prescale),
    .tick    (tick)
  );

  // Write address and data latched independently
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = aw_addr == gdc_pkg::ADDR_CTRL   || aw_addr == gdc_pkg::ADDR_PERIOD
               || aw_addr == gdc_pkg::ADDR_DUTY   || aw_addr == gdc_pkg::ADDR_STEP
               || aw_addr == gdc_pkg::ADDR_IRQ_STATUS || aw_addr == gdc_pkg::ADDR_IRQ_MASK
               || aw_addr == gdc_pkg::ADDR_PRESCALE || aw_addr == gdc_pkg::ADDR_STATUS;

  // Channel ready and write response
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gdc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? gdc_pkg::RESP_OKAY : gdc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl     <= 32'h0000_0000;
      period   <= gdc_pkg::PERIOD_RST;
      duty_tgt <= '0;
      step     <= gdc_pkg::STEP_RST;
      prescale <= gdc_pkg::PRESCALE_RST;
      irq_mask <= '0;
    end else if (wr_go) begin
      case (aw_addr)
        gdc_pkg::ADDR_CTRL:     ctrl     <= merge(ctrl, w_data, w_strb);
        gdc_pkg::ADDR_PERIOD:   period   <= DW'(merge(32'(period), w_data, w_strb));
        gdc_pkg::ADDR_DUTY:     duty_tgt <= DW'(merge(32'(duty_tgt), w_data, w_strb));
        gdc_pkg::ADDR_STEP:     step     <= DW'(merge(32'(step), w_data, w_strb));
        gdc_pkg::ADDR_PRESCALE: prescale <= DW'(merge(32'(prescale), w_data, w_strb));
        gdc_pkg::ADDR_IRQ_MASK: irq_mask <= EV_W_C'(merge(32'(irq_mask), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Read channel with data from registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gdc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= gdc_pkg::RESP_OKAY;
        case (s_axi_araddr)
          gdc_pkg::ADDR_CTRL:       s_axi_rdata <= ctrl;
          gdc_pkg::ADDR_PERIOD:     s_axi_rdata <= 32'(period);
          gdc_pkg::ADDR_DUTY:       s_axi_rdata <= 32'(duty_tgt);
          gdc_pkg::ADDR_STEP:       s_axi_rdata <= 32'(step);
          gdc_pkg::ADDR_PRESCALE:   s_axi_rdata <= 32'(prescale);
          gdc_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
          gdc_pkg::ADDR_IRQ_MASK:   s_axi_rdata <= 32'(irq_mask);
          gdc_pkg::ADDR_STATUS:     s_axi_rdata <= {duty_cur, 8'h00, 1'b0, undervoltage_lockout,
                                                    !thermal_warn_n, over_current, 1'b0, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gdc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Events feeding the sticky status
  always_comb begin
    ev = '0;
    ev[gdc_pkg::EV_THERM_WARN] = warn_q && !thermal_warn_n;
    ev[gdc_pkg::EV_OVERCUR]    = over_current && state != gdc_pkg::ST_IDLE;
    ev[gdc_pkg::EV_SOFT_DONE]  = state == gdc_pkg::ST_SOFT && period_end && duty_cur >= duty_tgt;
    ev[gdc_pkg::EV_LOCKOUT]    = undervoltage_lockout
                               && (state == gdc_pkg::ST_SOFT || state == gdc_pkg::ST_RUN);
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_status <= '0;
      warn_q     <= 1'b1;
      irq        <= 1'b0;
    end else begin
      warn_q <= thermal_warn_n;
      if (wr_go && aw_addr == gdc_pkg::ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~EV_W_C'(w_data & {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}})) | ev;
      end else begin
        irq_status <= irq_status | ev;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  assign period_end = tick && cnt >= period;

  // Pulse-width period counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == gdc_pkg::ST_IDLE || state == gdc_pkg::ST_WAIT) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= period_end ? '0 : cnt + 1'b1;
    end
  end

  // Sequencer and duty ramp
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state    <= gdc_pkg::ST_IDLE;
      duty_cur <= '0;
      gap_cnt  <= 8'h00;
    end else begin
      case (state)
        gdc_pkg::ST_IDLE: begin
          duty_cur <= '0;
          if (ctrl[gdc_pkg::CTRL_RUN] && !over_current) begin
            state <= gdc_pkg::ST_WAIT;
          end
        end
        gdc_pkg::ST_WAIT: begin
          if (!ctrl[gdc_pkg::CTRL_RUN]) begin
            state <= gdc_pkg::ST_IDLE;
          end else if (!undervoltage_lockout) begin
            state <= gdc_pkg::ST_SOFT;
          end
        end
        gdc_pkg::ST_SOFT: begin
          if (!ctrl[gdc_pkg::CTRL_RUN] || over_current || undervoltage_lockout) begin
            state   <= gdc_pkg::ST_STOP;
            gap_cnt <= 8'(gdc_pkg::STOP_GAP_CYC);
          end else if (period_end) begin
            if (duty_cur >= duty_tgt) begin
              state <= gdc_pkg::ST_RUN;
            end else if (duty_tgt - duty_cur > step) begin
              duty_cur <= duty_cur + step;
            end else begin
              duty_cur <= duty_tgt;
            end
          end
        end
        gdc_pkg::ST_RUN: begin
          if (!ctrl[gdc_pkg::CTRL_RUN] || over_current || undervoltage_lockout) begin
            state   <= gdc_pkg::ST_STOP;
            gap_cnt <= 8'(gdc_pkg::STOP_GAP_CYC);
          end else if (period_end) begin
            duty_cur <= duty_tgt;
          end
        end
        gdc_pkg::ST_STOP: begin
          if (gap_cnt == 8'h00) begin
            state <= gdc_pkg::ST_IDLE;
          end else begin
            gap_cnt <= gap_cnt - 8'h01;
          end
        end
        default: state <= gdc_pkg::ST_IDLE;
      endcase
    end
  end

  // Stage pins: enable drops first on stop, pulse-width released afterwards
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      driver_enable_n <= 1'b0;
      pwm_o           <= 1'b0;
      pwm_oe          <= 1'b0;
      skip_mode_n_o   <= 1'b0;
      skip_mode_n_oe  <= 1'b1;
    end else begin
      driver_enable_n <= state == gdc_pkg::ST_SOFT || state == gdc_pkg::ST_RUN;
      if (state == gdc_pkg::ST_SOFT || state == gdc_pkg::ST_RUN) begin
        pwm_oe <= 1'b1;
        pwm_o  <= cnt < duty_cur;
      end else if (state == gdc_pkg::ST_STOP) begin
        pwm_oe <= 1'b1;
        pwm_o  <= 1'b0;
      end else begin
        pwm_oe <= !ctrl[gdc_pkg::CTRL_IDLE_TRI];
        pwm_o  <= 1'b0;
      end
      skip_mode_n_oe <= !ctrl[gdc_pkg::CTRL_SKIP_MID];
      skip_mode_n_o  <= ctrl[gdc_pkg::CTRL_SKIP_CCM];
    end
  end
endmodule

/* logic/gdc_pkg.sv */
// Constants shared by the gate drive controller files
package gdc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_PERIOD     = 8'h04;
  localparam logic [7:0] ADDR_DUTY       = 8'h08;
  localparam logic [7:0] ADDR_STEP       = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
  localparam logic [7:0] ADDR_PRESCALE   = 8'h1C;

  // Control register fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_SKIP_CCM = 1;
  localparam int CTRL_SKIP_MID = 2;
  localparam int CTRL_IDLE_TRI = 3;

  // Event bits of status and mask registers
  localparam int EV_THERM_WARN = 0;
  localparam int EV_OVERCUR    = 1;
  localparam int EV_SOFT_DONE  = 2;
  localparam int EV_LOCKOUT    = 3;
  localparam int EV_W          = 4;

  // Reset values
  localparam logic [15:0] PERIOD_RST   = 16'h00FF;
  localparam logic [15:0] STEP_RST     = 16'h0001;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Enable-off to pulse-width release gap on shutdown
  localparam int CLK_MHZ      = 125;
  localparam int STOP_GAP_NS  = 1000;
  localparam int STOP_GAP_CYC = (STOP_GAP_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states, Gray along idle-wait-soft-run-stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_SOFT = 3'b011,
    ST_RUN  = 3'b010,
    ST_STOP = 3'b110
  } gdc_state_t;
endpackage

/* logic/gdc_tick_div.sv */
// Clock-enable divider producing the pulse-width counter tick
`timescale 1ns/10ps
module gdc_tick_div #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] divide,
  output logic              tick
);
  logic [W-1:0] count;

  // One tick every divide+1 clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= divide) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

/* verification/gdc_host_sva.sv */
// Protocol and sequencing assertions on the gate drive controller ports
`timescale 1ns/10ps
module gdc_host_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pwm_o,
  input wire logic        pwm_oe,
  input wire logic        driver_enable_n,
  input wire logic        undervoltage_lockout,
  input wire logic        over_current
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Bus answers hold and arrive on time
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // Stage sequencing
  a_pwm_needs_enable: assert property ($rose(pwm_o) |-> driver_enable_n)
    else $error("pulse before stage enable");
  a_enable_after_supply: assert property ($rose(driver_enable_n)
    |-> !$past(undervoltage_lockout))
    else $error("enable during lockout");
  a_overcur_stop: assert property (over_current && driver_enable_n
    |-> ##[1:3] !driver_enable_n)
    else $error("no stop on overcurrent");
  a_lockout_stop: assert property (undervoltage_lockout && driver_enable_n
    |-> ##[1:3] !driver_enable_n)
    else $error("no stop on lockout");
  a_stop_order: assert property ($fell(driver_enable_n)
    |=> (pwm_oe && !pwm_o) [*8])
    else $error("pulse released before enable");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_start: cover property ($rose(driver_enable_n));
  c_stop: cover property ($fell(driver_enable_n));
endmodule
bind gdc_host gdc_host_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pwm_o(pwm_o), .pwm_oe(pwm_oe), .driver_enable_n(driver_enable_n),
  .undervoltage_lockout(undervoltage_lockout), .over_current(over_current));

/* verification/gdc_stage_model.sv */
// Behavioural power stage model with decoded inputs and clock-counted delays
`timescale 1ns/10ps
module gdc_stage_model #(
  parameter int HOLD_CYC = 42
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pwm_o,
  input  wire logic pwm_oe,
  input  wire logic skip_mode_n_o,
  input  wire logic skip_mode_n_oe,
  input  wire logic driver_enable_n,
  input  wire logic supply_low,
  input  wire logic temp_warn,
  input  wire logic temp_shut,
  input  wire logic zero_cross_detect,
  output logic      high_side_gate,
  output logic      low_side_gate,
  output logic      undervoltage_lockout,
  output logic      thermal_warn_n
);
  logic [5:0] tri_cnt;
  logic       run_ok;
  // Weak pull-down: only a driven high enable level runs the stage
  assign run_ok = (driver_enable_n === 1'b1) && !supply_low && !temp_shut;
  assign undervoltage_lockout = supply_low;
  assign thermal_warn_n = !temp_warn;
  // Hold-off counter; an undriven input sits at the mid level
  always_ff @(posedge sys_clk) begin
    if (!rst_n || pwm_oe) begin
      tri_cnt <= 6'h00;
    end else if (tri_cnt < 6'(HOLD_CYC)) begin
      tri_cnt <= tri_cnt + 6'h01;
    end
  end
  // Gate commands with break-before-make
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run_ok) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
    end else if (pwm_oe) begin
      high_side_gate <= pwm_o && !low_side_gate;
      low_side_gate  <= !pwm_o && !high_side_gate;
    end else if (tri_cnt == 6'(HOLD_CYC)) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= low_side_gate && !zero_cross_detect
                        && !(skip_mode_n_oe && !skip_mode_n_o);
    end
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the gate drive controller and stage model
`timescale 1ns/10ps
module testbench;
  logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, pwm_o, pwm_oe;
  logic        skip_o, skip_oe, driver_enable_n, thermal_warn_n, undervoltage_lockout;
  logic        over_current, supply_low, temp_warn, temp_shut, zero_cross_detect;
  logic        high_side_gate, low_side_gate;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  wstrb;
  int          failures, total_checks, n;
  logic [7:0]  ra [5] = '{gdc_pkg::ADDR_PERIOD, gdc_pkg::ADDR_STEP, gdc_pkg::ADDR_PRESCALE,
                          gdc_pkg::ADDR_CTRL, gdc_pkg::ADDR_IRQ_MASK};
  logic [31:0] rv [5] = '{32'(gdc_pkg::PERIOD_RST), 32'(gdc_pkg::STEP_RST),
                          32'(gdc_pkg::PRESCALE_RST), 32'h0, 32'h0};
  gdc_host u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .skip_mode_n_o(skip_o),
    .skip_mode_n_oe(skip_oe), .driver_enable_n(driver_enable_n),
    .thermal_warn_n(thermal_warn_n), .undervoltage_lockout(undervoltage_lockout),
    .over_current(over_current));
  gdc_stage_model u_stage (.sys_clk(sys_clk), .rst_n(rst_n), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .skip_mode_n_o(skip_o), .skip_mode_n_oe(skip_oe), .driver_enable_n(driver_enable_n),
    .supply_low(supply_low), .temp_warn(temp_warn), .temp_shut(temp_shut),
    .zero_cross_detect(zero_cross_detect), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .undervoltage_lockout(undervoltage_lockout),
    .thermal_warn_n(thermal_warn_n));
  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    while (bvalid !== 1'b1) @(posedge sys_clk);
    r = bresp;
    bready <= 1'b0;
    // Let registered outputs take the new register value
    @(posedge sys_clk);
  endtask
  // Bus read: one word, data taken at the answer edge
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_en(input logic v);
    while (driver_enable_n !== v) @(posedge sys_clk);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Both gates on together is never allowed
  always @(negedge sys_clk) begin
    if (high_side_gate === 1'b1 && low_side_gate === 1'b1) begin
      failures++;
      $display("[FAIL] %0t both gates on", $time);
    end
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("[FAIL] %0t timeout", $time);
    conclude();
  end
  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, over_current, temp_warn, temp_shut} = 9'h000;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    supply_low = 1'b1;
    zero_cross_detect = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      chk(d, rv[i]);
      chk(32'(r), 32'(gdc_pkg::RESP_OKAY));
    end
    wr(8'h20, 32'h5A);
    chk(32'(r), 32'(gdc_pkg::RESP_SLVERR));
    rd(8'h20);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(gdc_pkg::RESP_SLVERR));
    wr(gdc_pkg::ADDR_CTRL, 32'h2);
    chk({skip_oe, skip_o}, 2'h3);
    wr(gdc_pkg::ADDR_CTRL, 32'h4);
    chk(skip_oe, 1'b0);
    wr(gdc_pkg::ADDR_CTRL, 32'h8);
    chk({skip_oe, skip_o, pwm_oe}, 3'h4);
    wr(gdc_pkg::ADDR_PERIOD, 32'hF);
    wr(gdc_pkg::ADDR_DUTY, 32'h8);
    wr(gdc_pkg::ADDR_STEP, 32'h2);
    wr(gdc_pkg::ADDR_IRQ_MASK, 32'h4);
    wr(gdc_pkg::ADDR_CTRL, 32'h1);
    repeat (10) @(posedge sys_clk);
    chk(driver_enable_n, 1'b0);
    rd(gdc_pkg::ADDR_STATUS);
    chk(d[2:0], 3'h1);
    supply_low <= 1'b0;
    wait_en(1'b1);
    while (irq !== 1'b1) @(posedge sys_clk);
    rd(gdc_pkg::ADDR_IRQ_STATUS);
    chk(d, 32'h4);
    rd(gdc_pkg::ADDR_STATUS);
    chk({d[31:16], d[2:0]}, {16'h8, 3'h2});
    n = 0;
    repeat (16) begin
      @(posedge sys_clk);
      n += (pwm_o === 1'b1);
    end
    chk(n, 8);
    wr(gdc_pkg::ADDR_IRQ_STATUS, 32'h4);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    temp_warn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(gdc_pkg::ADDR_IRQ_STATUS);
    chk(d, 32'h1);
    temp_warn <= 1'b0;
    wr(gdc_pkg::ADDR_IRQ_STATUS, 32'h1);
    rd(gdc_pkg::ADDR_IRQ_STATUS);
    chk(d, 32'h0);
    over_current <= 1'b1;
    wait_en(1'b0);
    repeat (140) @(posedge sys_clk);
    rd(gdc_pkg::ADDR_STATUS);
    chk(d[2:0], 3'h0);
    rd(gdc_pkg::ADDR_IRQ_STATUS);
    chk(d[1], 1'b1);
    over_current <= 1'b0;
    wait_en(1'b1);
    temp_shut <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({high_side_gate, low_side_gate}, 2'h0);
    temp_shut <= 1'b0;
    supply_low <= 1'b1;
    wait_en(1'b0);
    repeat (2) @(posedge sys_clk);
    chk({high_side_gate, low_side_gate}, 2'h0);
    rd(gdc_pkg::ADDR_IRQ_STATUS);
    chk(d[3], 1'b1);
    conclude();
  end
endmodule
